// ---- wave_kernel_state.sv ----
`timescale 1ns/1ps
// ====================================================================
// Per-wave architectural state: pointer, enable mask, status, counters.
// ====================================================================
// Functional notes
// RQ1: Keep 48-bit byte address of next instruction.
// RQ2: Wave creation loads first program instruction address.
// RQ3: Get/set/swap use even-indexed scalar register pairs.
// RQ4: Branch, get, swap relative to following instruction.
// RQ5: Software trap saves its own address.
// RQ6: Each enable mask bit gates one thread.
// RQ7: Mask written by scalar writes and compares.
// RQ8: Mask gates vector, share, export; not scalar.
// RQ9: Mask-zero flag kept and testable by branches.
// RQ10: Wave32 ignores upper mask half for flag.
// RQ11: Zero mask skips vector ALU except scalar-writers.
// RQ12: Wave64 memory drops one half; wave32 never.
// RQ13: Status word read-only, initialised at creation.
// RQ14: Condition bit: carry, compare result, logic nonzero.
// RQ15: Launcher priority bits 2:1, program priority 4:3.
// RQ16: Privilege bit 5 only inside trap handler.
// RQ17: Trap-present bit 6; clear means no traps.
// RQ18: Trace bit 7; clear drops program trace data.
// RQ19: Export stalls, wave sleeping, until bit 8 set.
// RQ20: Bits 9-11 mirror mask-zero, cond-zero, group membership.
// RQ21: Two 6-bit pending load and store counters.
// RQ22: 3-bit pending export counter.
// RQ23: 4-bit pending share and scalar counter.
// RQ24: Wave32 ignores upper half of condition mask.
// RQ25: Counters count up, down, saturate, never wrap.
module wave_kernel_state (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic create_i,
	input wire wave_state_pkg::wave_init_t init_i,
	input wire wave_state_pkg::pc_cmd_t pc_cmd_i,
	input wire logic [47:0] trap_handler_base_i,
	output logic pc_wr_valid_o,
	output logic [6:0] pc_wr_idx_o,
	output logic [63:0] pc_wr_data_o,
	output logic pc_cmd_err_o,
	output logic [47:0] instr_pointer_o,
	input wire logic cmpx_wr_i,
	input wire logic [63:0] cmpx_mask_i,
	input wire logic vcc_wr_i,
	input wire logic [63:0] vcc_i,
	input wire wave_state_pkg::scc_upd_t scc_i,
	input wire logic prio_wr_i,
	input wire logic [1:0] prio_i,
	input wire wave_state_pkg::issue_t issue_i,
	output logic iss_go_o,
	output logic [1:0] iss_pass_o,
	output logic [63:0] iss_lane_mask_o,
	output logic wave_sleep_o,
	input wire logic export_space_i,
	input wire logic trace_data_i,
	output logic trace_accept_o,
	input wire logic [3:0] cnt_inc_i,
	input wire logic [3:0] cnt_dec_i,
	output logic [63:0] exec_mask_o,
	output logic enable_mask_zero_flag_o,
	output logic vector_cond_zero_flag_o,
	output logic privilege_bit_o,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	import wave_state_pkg::*;

	logic [PC_W-1:0] pc_q;
	logic [MASK_W-1:0] exec_q;
	logic [MASK_W-1:0] vcc_q;
	logic scc_q;
	logic [1:0] lprio_q;
	logic [1:0] pprio_q;
	logic privilege_bit_q;
	logic trap_present_q;
	logic trace_q;
	logic exp_rdy_q;
	logic mwg_q;
	logic wave32_q;
	exp_state_t exp_state_q;
	logic [CNT_W-1:0] cnt_q [CNT_NUM];
	logic [MASK_W-1:0] exec_eff;
	logic [MASK_W-1:0] vcc_eff;
	logic emz;
	logic vcz;
	logic [PC_W-1:0] next_pc;
	logic even_pair;
	logic br_taken;
	logic [DATA_W-1:0] status_word;
	logic go_d;
	logic [1:0] pass_d;
	logic [MASK_W-1:0] mask_d;
	logic exp_block;

	// ====================================================================
	// Effective masks and zero flags.
	// ====================================================================
	// A wave32 wave never sees stale upper-half bits, so flags stay honest.
	assign exec_eff = wave32_q ? {{HALF_W{1'b0}}, exec_q[HALF_W-1:0]} : exec_q; // RQ10
	assign vcc_eff = wave32_q ? {{HALF_W{1'b0}}, vcc_q[HALF_W-1:0]} : vcc_q; // RQ24
	assign emz = ~|exec_eff; // RQ9
	assign vcz = ~|vcc_eff;
	assign exec_mask_o = exec_q;
	assign enable_mask_zero_flag_o = emz;
	assign vector_cond_zero_flag_o = vcz;
	assign privilege_bit_o = privilege_bit_q;
	assign instr_pointer_o = pc_q;

	// ====================================================================
	// Instruction pointer.
	// ====================================================================
	// Address of the following instruction; every relative result uses it.
	assign next_pc = pc_q + PC_W'(pc_cmd_i.len); // RQ4
	assign even_pair = ~pc_cmd_i.sreg[0]; // RQ3

	// Branch condition select; the mask-zero flag is directly testable.
	always_comb begin
		case (pc_cmd_i.cond)
			BR_ALWAYS: br_taken = 1'b1;
			BR_EMZ: br_taken = emz; // RQ9
			BR_EMNZ: br_taken = ~emz;
			BR_VCZ: br_taken = vcz;
			BR_VCNZ: br_taken = ~vcz;
			BR_SCC1: br_taken = scc_q;
			BR_SCC0: br_taken = ~scc_q;
			default: br_taken = 1'b0;
		endcase
	end

	// Pointer and privilege move together so a handler entry is atomic.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pc_q <= PC_RST;
			privilege_bit_q <= 1'b0;
		end else if (clk_en_i) begin
			if (create_i) begin
				pc_q <= init_i.start_pc; // RQ2
				privilege_bit_q <= 1'b0;
			end else if (pc_cmd_i.valid) begin
				case (pc_cmd_i.op)
					PC_STEP: pc_q <= next_pc; // RQ1
					PC_BRANCH: pc_q <= br_taken ? next_pc + pc_cmd_i.operand[PC_W-1:0] : next_pc; // RQ4
					PC_GET: pc_q <= next_pc;
					PC_SET, PC_SWAP: pc_q <= even_pair ? pc_cmd_i.operand[PC_W-1:0] : next_pc; // RQ3
					PC_TRAP: begin
						// Without a handler the trap only steps the pointer to the next instruction.
						if (trap_present_q) begin // RQ17
							pc_q <= trap_handler_base_i;
							privilege_bit_q <= 1'b1; // RQ16
						end else begin
							pc_q <= next_pc;
						end
					end
					PC_RETURN: begin
						pc_q <= pc_cmd_i.operand[PC_W-1:0];
						privilege_bit_q <= 1'b0; // RQ16
					end
					default: pc_q <= pc_q;
				endcase
			end
		end
	end

	// Pointer values written back to scalar register pairs.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pc_wr_valid_o <= 1'b0;
			pc_wr_idx_o <= 7'h00;
			pc_wr_data_o <= 64'h0;
			pc_cmd_err_o <= 1'b0;
		end else if (clk_en_i) begin
			pc_wr_valid_o <= 1'b0;
			pc_cmd_err_o <= 1'b0;
			pc_wr_idx_o <= pc_cmd_i.sreg;
			if (pc_cmd_i.valid && !create_i) begin
				case (pc_cmd_i.op)
					PC_GET, PC_SWAP: begin
						pc_wr_valid_o <= even_pair; // RQ3
						pc_cmd_err_o <= ~even_pair;
						pc_wr_data_o <= {{(OPND_W-PC_W){1'b0}}, next_pc}; // RQ4
					end
					PC_SET: pc_cmd_err_o <= ~even_pair; // RQ3
					PC_TRAP: begin
						pc_wr_valid_o <= trap_present_q;
						pc_wr_data_o <= {{(OPND_W-PC_W){1'b0}}, pc_q}; // RQ5
					end
					default: pc_wr_valid_o <= 1'b0;
				endcase
			end
		end
	end

	// ====================================================================
	// Enable and condition masks.
	// ====================================================================
	// A compare result wins over a bus write in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			exec_q <= MASK_RST;
			vcc_q <= MASK_RST;
		end else if (clk_en_i) begin
			if (create_i) begin
				exec_q <= init_i.exec_init;
				vcc_q <= MASK_RST;
			end else begin
				if (cmpx_wr_i) begin
					exec_q <= cmpx_mask_i; // RQ7
				end else if (reg_wr_i && reg_addr_i == EXEC_LO_OFS) begin
					exec_q[HALF_W-1:0] <= reg_wdata_i; // RQ7
				end else if (reg_wr_i && reg_addr_i == EXEC_HI_OFS) begin
					exec_q[MASK_W-1:HALF_W] <= reg_wdata_i;
				end
				if (vcc_wr_i) begin
					vcc_q <= vcc_i;
				end
			end
		end
	end

	// ====================================================================
	// Status fields.
	// ====================================================================
	// Only creation and hardware events change these; the bus cannot.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			scc_q <= 1'b0;
			lprio_q <= 2'h0;
			pprio_q <= 2'h0;
			trap_present_q <= 1'b0;
			trace_q <= 1'b0;
			mwg_q <= 1'b0;
			wave32_q <= 1'b0;
		end else if (clk_en_i) begin
			if (create_i) begin
				scc_q <= 1'b0; // RQ13
				lprio_q <= init_i.launcher_priority; // RQ15
				pprio_q <= 2'h0;
				trap_present_q <= init_i.trap_present;
				trace_q <= init_i.trace_enable;
				mwg_q <= init_i.multi_wave_group;
				wave32_q <= init_i.wave32;
			end else begin
				if (prio_wr_i) begin
					pprio_q <= prio_i; // RQ15
				end
				if (scc_i.valid) begin
					case (scc_i.kind)
						SCC_CARRY, SCC_COMPARE: scc_q <= scc_i.value; // RQ14
						SCC_LOGIC: scc_q <= |scc_i.result; // RQ14
						default: scc_q <= scc_q;
					endcase
				end
			end
		end
	end

	// Program trace data is dropped while tracing is off.
	assign trace_accept_o = trace_data_i & trace_q; // RQ18

	// Read-only status word image.
	always_comb begin
		status_word = 32'h0;
		status_word[SCC_BIT] = scc_q;
		status_word[LPRIO_LSB +: 2] = lprio_q; // RQ15
		status_word[PPRIO_LSB +: 2] = pprio_q;
		status_word[PRIVILEGE_BIT_BIT] = privilege_bit_q; // RQ16
		status_word[TRAP_PRESENT_BIT] = trap_present_q; // RQ17
		status_word[TRACE_BIT] = trace_q; // RQ18
		status_word[EXPORT_RDY_BIT] = exp_rdy_q; // RQ19
		status_word[EMZ_BIT] = emz; // RQ20
		status_word[VCZ_BIT] = vcz;
		status_word[MWG_BIT] = mwg_q;
	end

	// ====================================================================
	// Issue gating and pass skipping.
	// ====================================================================
	// Scalar work is never masked; vector classes get the effective mask.
	always_comb begin
		go_d = 1'b1;
		pass_d = 2'b01;
		mask_d = {MASK_W{1'b1}}; // RQ8
		exp_block = 1'b0;
		case (issue_i.cls)
			CLS_SCALAR: go_d = 1'b1; // RQ8
			CLS_VALU: begin
				mask_d = exec_eff; // RQ6
				pass_d = wave32_q ? {1'b0, ~emz} : {|exec_q[MASK_W-1:HALF_W], |exec_q[HALF_W-1:0]};
				go_d = |pass_d; // RQ11
			end
			CLS_VALU_SCALAR_REGISTER: begin
				mask_d = exec_eff;
				pass_d = wave32_q ? 2'b01 : 2'b11; // RQ11
			end
			CLS_VMEM: begin
				mask_d = exec_eff;
				// Both halves empty still issues the low pass with no lanes.
				if (!wave32_q && (|exec_q[MASK_W-1:HALF_W] || |exec_q[HALF_W-1:0])) begin
					pass_d = {|exec_q[MASK_W-1:HALF_W], |exec_q[HALF_W-1:0]}; // RQ12
				end
			end
			CLS_SHARE: begin
				mask_d = exec_eff; // RQ8
				pass_d = wave32_q ? 2'b01 : 2'b11;
			end
			CLS_EXPORT: begin
				mask_d = exec_eff;
				pass_d = wave32_q ? 2'b01 : 2'b11;
				go_d = exp_rdy_q; // RQ19
				exp_block = ~exp_rdy_q;
			end
			default: go_d = 1'b0;
		endcase
	end

	// Export sleep: a blocked export is held here and released on space.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			exp_state_q <= EXP_RUN;
			exp_rdy_q <= 1'b0;
			iss_go_o <= 1'b0;
			iss_pass_o <= 2'b00;
			iss_lane_mask_o <= MASK_RST;
		end else if (clk_en_i) begin
			if (export_space_i) begin
				exp_rdy_q <= 1'b1; // RQ19
			end else if (create_i) begin
				exp_rdy_q <= 1'b0;
			end
			iss_go_o <= 1'b0;
			case (exp_state_q)
				EXP_RUN: begin
					if (issue_i.valid && !create_i) begin
						iss_go_o <= go_d;
						iss_pass_o <= pass_d;
						iss_lane_mask_o <= mask_d;
						if (exp_block) begin
							exp_state_q <= EXP_SLEEP; // RQ19
						end
					end
				end
				EXP_SLEEP: begin
					if (create_i) begin
						exp_state_q <= EXP_RUN;
					end else if (exp_rdy_q) begin
						iss_go_o <= 1'b1; // RQ19
						iss_pass_o <= wave32_q ? 2'b01 : 2'b11;
						iss_lane_mask_o <= exec_eff;
						exp_state_q <= EXP_RUN;
					end
				end
				default: exp_state_q <= EXP_RUN;
			endcase
		end
	end

	assign wave_sleep_o = (exp_state_q == EXP_SLEEP);

	// ====================================================================
	// Outstanding-operation counters.
	// ====================================================================
	// Saturation hides overflow; the sequencer must not over-issue.
	for (genvar g = 0; g < CNT_NUM; g++) begin : g_cnt
		always_ff @(posedge sys_clk_i) begin
			if (!resetn_i) begin
				cnt_q[g] <= '0;
			end else if (clk_en_i) begin
				if (create_i) begin
					cnt_q[g] <= '0;
				end else if (cnt_inc_i[g] && !cnt_dec_i[g] && cnt_q[g] != CNT_MAX[g]) begin
					cnt_q[g] <= cnt_q[g] + 6'h01; // RQ25
				end else if (cnt_dec_i[g] && !cnt_inc_i[g] && cnt_q[g] != 6'h00) begin
					cnt_q[g] <= cnt_q[g] - 6'h01; // RQ25
				end
			end
		end
		cnt_bound_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ21
			cnt_q[g] <= CNT_MAX[g])
			else $error("pending counter above its maximum");
	end

	// ====================================================================
	// Register read port.
	// ====================================================================
	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= RDATA_RST;
		end else if (clk_en_i) begin
			reg_rdata_o <= RDATA_RST;
			if (reg_rd_i) begin
				case (reg_addr_i)
					STATUS_OFS: reg_rdata_o <= status_word; // RQ13
					PC_LO_OFS: reg_rdata_o <= pc_q[HALF_W-1:0];
					PC_HI_OFS: reg_rdata_o <= {{(MASK_W-PC_W){1'b0}}, pc_q[PC_W-1:HALF_W]};
					EXEC_LO_OFS: reg_rdata_o <= exec_q[HALF_W-1:0]; // RQ7
					EXEC_HI_OFS: reg_rdata_o <= exec_q[MASK_W-1:HALF_W];
					COUNT_OFS: begin
						reg_rdata_o[CNT_LSB[0] +: 6] <= cnt_q[0]; // RQ21
						reg_rdata_o[CNT_LSB[1] +: 6] <= cnt_q[1];
						reg_rdata_o[CNT_LSB[2] +: 3] <= cnt_q[2][2:0]; // RQ22
						reg_rdata_o[CNT_LSB[3] +: 4] <= cnt_q[3][3:0]; // RQ23
					end
					VCC_LO_OFS: reg_rdata_o <= vcc_q[HALF_W-1:0];
					VCC_HI_OFS: reg_rdata_o <= vcc_q[MASK_W-1:HALF_W];
					default: reg_rdata_o <= RDATA_RST;
				endcase
			end
		end
	end

	// ====================================================================
	// Checks.
	// ====================================================================
	step_advance_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ1
		clk_en_i && !create_i && pc_cmd_i.valid && pc_cmd_i.op == PC_STEP
		|=> pc_q == $past(pc_q) + PC_W'($past(pc_cmd_i.len)))
		else $error("pointer did not advance by instruction length");

	create_load_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ2
		clk_en_i && create_i |=> pc_q == $past(init_i.start_pc) && !privilege_bit_q)
		else $error("creation did not load start address");

	get_value_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ4
		clk_en_i && !create_i && pc_cmd_i.valid && pc_cmd_i.op == PC_GET && !pc_cmd_i.sreg[0]
		|=> pc_wr_valid_o && pc_wr_data_o[PC_W-1:0] == pc_q && pc_wr_idx_o[0] == 1'b0)
		else $error("get returned wrong address");

	odd_pair_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ3
		clk_en_i && !create_i && pc_cmd_i.valid && pc_cmd_i.sreg[0]
		&& (pc_cmd_i.op == PC_GET || pc_cmd_i.op == PC_SWAP) |=> !pc_wr_valid_o && pc_cmd_err_o)
		else $error("odd register pair accepted");

	trap_save_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ5
		clk_en_i && !create_i && pc_cmd_i.valid && pc_cmd_i.op == PC_TRAP && trap_present_q
		|=> pc_wr_data_o[PC_W-1:0] == $past(pc_q) && privilege_bit_q && pc_q == $past(trap_handler_base_i))
		else $error("trap saved wrong address");

	no_trap_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ17
		clk_en_i && !create_i && pc_cmd_i.valid && pc_cmd_i.op == PC_TRAP && !trap_present_q
		|=> !$rose(privilege_bit_q) && !pc_wr_valid_o)
		else $error("trap taken without handler");

	mask_zero_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ10
		wave32_q |-> enable_mask_zero_flag_o == (exec_q[HALF_W-1:0] == 32'h0))
		else $error("wave32 mask-zero flag uses upper half");

	vmem_pass_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ12
		clk_en_i && !create_i && exp_state_q == EXP_RUN && issue_i.valid && issue_i.cls == CLS_VMEM
		|=> iss_go_o && iss_pass_o != 2'b00 && (!$past(wave32_q) || iss_pass_o == 2'b01))
		else $error("memory instruction fully skipped");

	scalar_register_writer_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ11
		clk_en_i && !create_i && exp_state_q == EXP_RUN && issue_i.valid
		&& issue_i.cls == CLS_VALU_SCALAR_REGISTER |=> iss_go_o)
		else $error("scalar-writing vector op skipped");

	scalar_ungated_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ8
		clk_en_i && !create_i && exp_state_q == EXP_RUN && issue_i.valid && issue_i.cls == CLS_SCALAR
		|=> iss_go_o && &iss_lane_mask_o)
		else $error("scalar op gated by mask");

	export_stall_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ19
		wave_sleep_o && !exp_rdy_q |-> !iss_go_o ##1 (wave_sleep_o || iss_go_o || $past(create_i)))
		else $error("export released without space");

	status_ro_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RQ13
		clk_en_i && reg_wr_i && reg_addr_i == STATUS_OFS && !create_i && !scc_i.valid
		&& !prio_wr_i |=> lprio_q == $past(lprio_q) && trap_present_q == $past(trap_present_q))
		else $error("status word changed by bus write");

endmodule : wave_kernel_state

// ---- wave_state_pkg.sv ----
// ====================================================================
// Shared constants and carriers for the per-wave state block.
// ====================================================================
package wave_state_pkg;

	// Datapath widths.
	localparam int PC_W = 48;
	localparam int MASK_W = 64;
	localparam int HALF_W = 32;
	localparam int OPND_W = 64;
	localparam int SREG_W = 7;
	localparam int LEN_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] PC_LO_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] PC_HI_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] EXEC_LO_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] EXEC_HI_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] VCC_LO_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] VCC_HI_OFS = 8'h1C;

	// Status word field positions.
	localparam int SCC_BIT = 0;
	localparam int LPRIO_LSB = 1;
	localparam int PPRIO_LSB = 3;
	localparam int PRIVILEGE_BIT_BIT = 5;
	localparam int TRAP_PRESENT_BIT = 6;
	localparam int TRACE_BIT = 7;
	localparam int EXPORT_RDY_BIT = 8;
	localparam int EMZ_BIT = 9;
	localparam int VCZ_BIT = 10;
	localparam int MWG_BIT = 11;

	// Outstanding-operation counters: load, store, export, share/scalar.
	localparam int CNT_NUM = 4;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_MAX [CNT_NUM] = '{6'h3F, 6'h3F, 6'h07, 6'h0F};
	localparam int CNT_LSB [CNT_NUM] = '{0, 8, 16, 24};

	// Reset values.
	localparam logic [PC_W-1:0] PC_RST = 48'h0;
	localparam logic [MASK_W-1:0] MASK_RST = 64'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0;

	typedef enum logic [2:0] {
		PC_STEP = 3'h0, PC_BRANCH = 3'h1, PC_GET = 3'h2, PC_SET = 3'h3,
		PC_SWAP = 3'h4, PC_TRAP = 3'h5, PC_RETURN = 3'h6
	} pc_op_t;

	typedef enum logic [2:0] {
		BR_ALWAYS = 3'h0, BR_EMZ = 3'h1, BR_EMNZ = 3'h2, BR_VCZ = 3'h3,
		BR_VCNZ = 3'h4, BR_SCC1 = 3'h5, BR_SCC0 = 3'h6
	} br_cond_t;

	typedef enum logic [1:0] {
		SCC_CARRY = 2'h0, SCC_COMPARE = 2'h1, SCC_LOGIC = 2'h2
	} scc_kind_t;

	typedef enum logic [2:0] {
		CLS_SCALAR = 3'h0, CLS_VALU = 3'h1, CLS_VALU_SCALAR_REGISTER = 3'h2,
		CLS_VMEM = 3'h3, CLS_SHARE = 3'h4, CLS_EXPORT = 3'h5
	} op_class_t;

	typedef enum logic [1:0] {
		EXP_RUN = 2'b01, EXP_SLEEP = 2'b10
	} exp_state_t;

	typedef struct packed {
		logic [PC_W-1:0] start_pc;
		logic [MASK_W-1:0] exec_init;
		logic [1:0] launcher_priority;
		logic trap_present;
		logic trace_enable;
		logic multi_wave_group;
		logic wave32;
	} wave_init_t;

	typedef struct packed {
		logic valid;
		pc_op_t op;
		br_cond_t cond;
		logic [LEN_W-1:0] len;
		logic [SREG_W-1:0] sreg;
		logic [OPND_W-1:0] operand;
	} pc_cmd_t;

	typedef struct packed {
		logic valid;
		scc_kind_t kind;
		logic value;
		logic [OPND_W-1:0] result;
	} scc_upd_t;

	typedef struct packed {
		logic valid;
		op_class_t cls;
	} issue_t;

endpackage : wave_state_pkg

// ---- export_alloc_model.sv ----
`timescale 1ns/1ps
// ====================================================================
// Export buffer allocator: grants space a set time after the wave sleeps.
// ====================================================================
module export_alloc_model (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic wave_sleep_i,
	input wire logic [3:0] delay_i,
	output logic export_space_o
);
	logic [3:0] wait_q;
	// One grant per sleep for delays below 15; the count parks at 15, so a delay of 15 holds the grant high.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || !wave_sleep_i) begin
			wait_q <= 4'h0;
			export_space_o <= 1'b0;
		end else begin
			export_space_o <= (wait_q == delay_i);
			if (wait_q != 4'hF) begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule : export_alloc_model

// ---- wave_kernel_state_bench.sv ----
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench for the per-wave state block.
// ====================================================================
module wave_kernel_state_bench;
	import wave_state_pkg::*;
	typedef struct packed {wave_init_t w; logic [31:0] st;} row_t;
	logic clk = 1'b0, rstn = 1'b0, cre = 1'b0, cmpx = 1'b0, vccw = 1'b0;
	logic pw = 1'b0, trd = 1'b0, space, rw = 1'b0, rr = 1'b0, ce = 1'b1;
	logic [1:0] prio = 2'h0;
	logic [3:0] inc = 4'h0, dec = 4'h0;
	logic [7:0] ra = 8'h0;
	logic [31:0] wd = 32'h0;
	logic [63:0] cm = 64'h0, vc = 64'h0;
	wave_init_t ini = '0;
	pc_cmd_t pcc = '0;
	scc_upd_t sc = '0;
	issue_t iss = '0;
	logic wv, er, go, slp, tacc, ezf, vzf, privilege_bit, got;
	logic [6:0] wi;
	logic [63:0] wdat, lm, em;
	logic [47:0] ip;
	logic [1:0] pas;
	logic [31:0] rdat;
	int num_errors = 0, n_compared = 0;
	row_t rows [3] = '{
		'{'{48'h1000, 64'h1, 2'd3, 1'b1, 1'b1, 1'b1, 1'b0}, 32'hCC6},
		'{'{48'h2000, 64'hFFFFFFFF00000000, 2'd1, 1'b0, 1'b0, 1'b0, 1'b1}, 32'h602},
		'{'{48'h100, 64'h0, 2'd2, 1'b1, 1'b1, 1'b0, 1'b0}, 32'h6C4}};

	wave_kernel_state u_dut (.sys_clk_i(clk), .resetn_i(rstn), .clk_en_i(ce),
		.create_i(cre), .init_i(ini), .pc_cmd_i(pcc), .trap_handler_base_i(48'h8000),
		.pc_wr_valid_o(wv), .pc_wr_idx_o(wi), .pc_wr_data_o(wdat), .pc_cmd_err_o(er),
		.instr_pointer_o(ip), .cmpx_wr_i(cmpx), .cmpx_mask_i(cm), .vcc_wr_i(vccw),
		.vcc_i(vc), .scc_i(sc), .prio_wr_i(pw), .prio_i(prio), .issue_i(iss),
		.iss_go_o(go), .iss_pass_o(pas), .iss_lane_mask_o(lm), .wave_sleep_o(slp),
		.export_space_i(space), .trace_data_i(trd), .trace_accept_o(tacc),
		.cnt_inc_i(inc), .cnt_dec_i(dec), .exec_mask_o(em),
		.enable_mask_zero_flag_o(ezf), .vector_cond_zero_flag_o(vzf), .privilege_bit_o(privilege_bit),
		.reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw), .reg_rd_i(rr), .reg_rdata_o(rdat));

	export_alloc_model u_alloc (.sys_clk_i(clk), .resetn_i(rstn), .wave_sleep_i(slp),
		.delay_i(4'h3), .export_space_o(space));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk = ~clk;
	end

	// Wide enough for the longest concatenation compared in one call.
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Register read: strobe one cycle, data stands only in the next cycle.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) ra <= a;
		rr <= 1'b1;
		@(posedge clk) rr <= 1'b0;
		#1 chk(rdat, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) ra <= a;
		wd <= d;
		rw <= 1'b1;
		@(posedge clk) rw <= 1'b0;
	endtask : wr

	task automatic pcop(input pc_op_t op, input logic [6:0] s, input logic [63:0] v);
		@(posedge clk) pcc <= '{1'b1, op, BR_ALWAYS, 4'h4, s, v};
		@(posedge clk) pcc.valid <= 1'b0;
		#1;
	endtask : pcop

	task automatic isu(input op_class_t c);
		@(posedge clk) iss <= '{1'b1, c};
		@(posedge clk) iss.valid <= 1'b0;
		#1;
	endtask : isu

	task automatic print_verdict;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// Cuts a hang short; the whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd(STATUS_OFS, 32'h600);
		// Each row creates a wave and checks the status word it starts with.
		foreach (rows[k]) begin
			@(posedge clk) cre <= 1'b1;
			ini <= rows[k].w;
			@(posedge clk) cre <= 1'b0;
			#1 chk(ip, rows[k].w.start_pc);
			chk(ezf, rows[k].st[9]);
			chk(vzf, rows[k].st[10]);
			rd(STATUS_OFS, rows[k].st);
		end
		wr(STATUS_OFS, 32'hFFFFFFFF);
		rd(STATUS_OFS, 32'h6C4);
		@(posedge clk) trd <= 1'b1;
		#1 chk(tacc, 1'b1);
		isu(CLS_VALU);
		chk(go, 1'b0);
		isu(CLS_VALU_SCALAR_REGISTER);
		chk({go, pas}, 3'b111);
		isu(CLS_VMEM);
		chk({go, pas}, 3'b101);
		isu(CLS_SCALAR);
		chk({go, lm}, {1'b1, 64'hFFFFFFFFFFFFFFFF});
		@(posedge clk) cmpx <= 1'b1;
		cm <= 64'hFFFF000000000000;
		@(posedge clk) cmpx <= 1'b0;
		#1 chk({ezf, em}, {1'b0, 64'hFFFF000000000000});
		rd(EXEC_HI_OFS, 32'hFFFF0000);
		isu(CLS_VMEM);
		chk({go, pas}, 3'b110);
		pcop(PC_GET, 7'd2, 64'h0);
		chk({wv, wi, wdat, ip}, {1'b1, 7'd2, 64'h104, 48'h104});
		pcop(PC_BRANCH, 7'd0, 64'h20);
		chk(ip, 48'h128);
		pcop(PC_TRAP, 7'd0, 64'h0);
		chk({privilege_bit, ip, wdat}, {1'b1, 48'h8000, 64'h128});
		pcop(PC_GET, 7'd3, 64'h0);
		chk({er, wv}, 2'b10);
		pcop(PC_STEP, 7'h00, 64'h0);
		chk(ip, 48'h8008);
		pcop(PC_SWAP, 7'h04, 64'h200);
		chk({wv, wi, wdat, ip}, {1'b1, 7'h04, 64'h800C, 48'h200});
		// With the clock enable low a step must leave the pointer frozen.
		@(posedge clk) ce <= 1'b0;
		pcop(PC_STEP, 7'h00, 64'h0);
		chk(ip, 48'h200);
		@(posedge clk) ce <= 1'b1;
		@(posedge clk) sc <= '{1'b1, SCC_LOGIC, 1'b0, 64'h4};
		pw <= 1'b1;
		prio <= 2'd2;
		vccw <= 1'b1;
		vc <= 64'h1;
		@(posedge clk) sc.valid <= 1'b0;
		pw <= 1'b0;
		vccw <= 1'b0;
		rd(STATUS_OFS, 32'h0F5);
		chk(vzf, 1'b0);
		isu(CLS_EXPORT);
		chk({go, slp}, 2'b01);
		got = 1'b0;
		repeat (20) begin
			@(posedge clk) #1 got = got | go;
		end
		chk({got, slp}, 2'b10);
		rd(STATUS_OFS, 32'h1F5);
		@(posedge clk) inc <= 4'hF;
		repeat (70) @(posedge clk);
		inc <= 4'h0;
		rd(COUNT_OFS, 32'h0F073F3F);
		@(posedge clk) dec <= 4'hF;
		@(posedge clk) dec <= 4'h0;
		rd(COUNT_OFS, 32'h0E063E3E);
		@(posedge clk) rstn <= 1'b0;
		@(posedge clk) rstn <= 1'b1;
		#1 chk({ip, em}, 112'h0);
		// Reset clears the handler flag, so a trap must only step on.
		pcop(PC_TRAP, 7'h00, 64'h0);
		chk({privilege_bit, wv, ip}, {1'b0, 1'b0, 48'h4});
		print_verdict();
	end
endmodule : wave_kernel_state_bench
